// file: design/reset_pin_sequencer_cfg.svh
`ifndef RESET_PIN_SEQUENCER_CFG_SVH
`define RESET_PIN_SEQUENCER_CFG_SVH

// ----------------------------------------------------------------------
// sequence timing, in system oscillator cycles
// ----------------------------------------------------------------------
`define RPS_TIMER_WIDTH 8
`define RPS_DRIVE_CYCLES 8'h80
`define RPS_SAMPLE_DELAY_CYCLES 8'h40

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RPS_OSC_CFG_RESET 1'b1
`define RPS_SYNC_RESET 2'h3

`endif

// file: design/reset_pin_sequencer_pkg.sv
package reset_pin_sequencer_pkg;

  // gray codes along drive -> wait -> sample -> run
  typedef enum logic [1:0] {
    ST_DRIVE = 2'h0,
    ST_WAIT = 2'h1,
    ST_SAMPLE = 2'h3,
    ST_RUN = 2'h2
  } seq_state_e;

  typedef enum logic [1:0] {
    VEC_EXTERNAL = 2'h0,
    VEC_WATCHDOG = 2'h1,
    VEC_CLOCK_MONITOR = 2'h2
  } reset_vector_e;

endpackage : reset_pin_sequencer_pkg

// file: design/seq_timer_if.sv
`timescale 1ns/1ns
`include "reset_pin_sequencer_cfg.svh"

interface seq_timer_if;
  logic restart;
  logic [`RPS_TIMER_WIDTH-1:0] limit;
  logic expired;

  modport ctrl (output restart, output limit, input expired);
  modport timer (input restart, input limit, output expired);
endinterface : seq_timer_if

// file: design/seq_timer.sv
`timescale 1ns/1ns
`include "reset_pin_sequencer_cfg.svh"

module seq_timer #(
  parameter int WIDTH = `RPS_TIMER_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  seq_timer_if.timer tmr
);

  logic [WIDTH-1:0] count_q;

  // ----------------------------------------------------------------------
  // count that stops at expiry, restarted by the sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (clk_en) begin
      if (tmr.restart) begin
        count_q <= '0;
      end else if (!tmr.expired) begin
        count_q <= count_q + WIDTH'(1);
      end
    end
  end

  // expires on the last cycle of the interval, so an interval of n
  // cycles spans exactly n edges including the restart edge
  assign tmr.expired = (count_q == WIDTH'(tmr.limit - WIDTH'(1)));

endmodule : seq_timer

// file: design/reset_pin_sequencer.sv
`timescale 1ns/1ns
`include "reset_pin_sequencer_cfg.svh"

module reset_pin_sequencer
  import reset_pin_sequencer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic watchdog_reset_source,
  input wire logic clock_monitor_reset_source,
  input wire logic self_clock_mode,
  input wire logic full_stop,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic reset_pin_pullup_en,
  input wire logic port_e_bit_seven_in,
  output logic port_e_bit_seven_out,
  output logic port_e_bit_seven_oe,
  output logic port_e_bit_seven_pullup_en,
  input wire logic double_bus_clock_out,
  input wire logic alt_clock_sel,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic gpio_in,
  output logic core_reset,
  output reset_vector_e reset_vector,
  output logic osc_config_select_n,
  output logic full_swing_pierce_sel
);

  seq_state_e state_q;
  logic [1:0] rpin_sync_q;
  logic [1:0] opin_sync_q;
  logic por_q;
  logic wd_q;
  logic cm_q;
  logic scm_q;
  logic stop_q;
  logic internal_req;
  logic start_req;
  logic cfg_update;
  logic osc_cfg_q;
  logic reset_oe_q;
  logic core_reset_q;
  reset_vector_e vector_q;
  logic pe7_out_q;
  logic pe7_oe_q;
  logic pe7_pu_q;
  logic gpio_in_q;

  seq_timer_if tmr ();

  seq_timer #(
    .WIDTH(`RPS_TIMER_WIDTH)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .tmr(tmr)
  );

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // both reset high, matching the pullups on the two pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rpin_sync_q <= `RPS_SYNC_RESET;
    end else if (clk_en) begin
      rpin_sync_q <= {rpin_sync_q[0], reset_pin_in};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opin_sync_q <= `RPS_SYNC_RESET;
    end else if (clk_en) begin
      opin_sync_q <= {opin_sync_q[0], port_e_bit_seven_in};
    end
  end

  // ----------------------------------------------------------------------
  // reset requests
  // ----------------------------------------------------------------------
  assign internal_req = watchdog_reset_source | clock_monitor_reset_source;
  // an external low only starts a sequence from run; inside the sequence
  // the pin low is our own drive or the level still to be sampled
  assign start_req = internal_req |
                     ((state_q == ST_RUN) & ~rpin_sync_q[1]);

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    tmr.restart = 1'b0;
    tmr.limit = `RPS_DRIVE_CYCLES;
    case (state_q)
      ST_DRIVE: begin
        // restart on leaving too, so wait begins with a fresh count
        tmr.restart = internal_req | tmr.expired;
        tmr.limit = `RPS_DRIVE_CYCLES;
      end
      ST_WAIT: begin
        tmr.restart = internal_req | tmr.expired;
        tmr.limit = `RPS_SAMPLE_DELAY_CYCLES;
      end
      ST_SAMPLE: begin
        tmr.restart = 1'b1;
        tmr.limit = `RPS_DRIVE_CYCLES;
      end
      ST_RUN: begin
        tmr.restart = 1'b1;
        tmr.limit = `RPS_DRIVE_CYCLES;
      end
      default: begin
        tmr.restart = 1'b1;
        tmr.limit = `RPS_DRIVE_CYCLES;
      end
    endcase
  end

  // timer counts in drive and wait; restart is low there except on
  // a new request or on expiry, so drive and wait hold for exactly their intervals
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_DRIVE;
    end else if (clk_en) begin
      case (state_q)
        ST_DRIVE: begin
          if (!internal_req && tmr.expired) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (internal_req) begin
            state_q <= ST_DRIVE;
          end else if (tmr.expired) begin
            state_q <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          state_q <= internal_req ? ST_DRIVE : ST_RUN;
        end
        ST_RUN: begin
          if (start_req) begin
            state_q <= ST_DRIVE;
          end
        end
        default: begin
          state_q <= ST_DRIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------------
  // a request in the sample cycle restarts the sequence, so set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      por_q <= 1'b1;
      wd_q <= 1'b0;
      cm_q <= 1'b0;
      scm_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == ST_SAMPLE && !internal_req) begin
        por_q <= 1'b0;
        wd_q <= 1'b0;
        cm_q <= 1'b0;
        scm_q <= 1'b0;
        stop_q <= 1'b0;
      end else if (start_req || state_q != ST_RUN) begin
        wd_q <= wd_q | watchdog_reset_source;
        cm_q <= cm_q | clock_monitor_reset_source;
        if (state_q == ST_RUN) begin
          scm_q <= self_clock_mode;
          stop_q <= full_stop;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // vector select and core reset
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vector_q <= VEC_EXTERNAL;
    end else if (clk_en && state_q == ST_SAMPLE && !internal_req) begin
      if (!rpin_sync_q[1]) begin
        vector_q <= VEC_EXTERNAL;
      end else if (cm_q) begin
        vector_q <= VEC_CLOCK_MONITOR;
      end else if (wd_q) begin
        vector_q <= VEC_WATCHDOG;
      end else begin
        vector_q <= VEC_EXTERNAL;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_reset_q <= 1'b1;
      reset_oe_q <= 1'b1;
    end else if (clk_en) begin
      core_reset_q <= !(state_q == ST_SAMPLE && !internal_req) &&
                      !(state_q == ST_RUN && !start_req);
      reset_oe_q <= (state_q == ST_DRIVE && !(tmr.expired &&
                     !internal_req)) || (state_q != ST_DRIVE &&
                     start_req);
    end
  end

  // ----------------------------------------------------------------------
  // oscillator configuration latch
  // ----------------------------------------------------------------------
  assign cfg_update = por_q | cm_q | scm_q | stop_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_cfg_q <= `RPS_OSC_CFG_RESET;
    end else if (clk_en && state_q == ST_SAMPLE && !internal_req &&
                 cfg_update) begin
      osc_cfg_q <= opin_sync_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // osc select pin function
  // ----------------------------------------------------------------------
  // alternate drive only once the core is out of reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pe7_out_q <= 1'b0;
      pe7_oe_q <= 1'b0;
      pe7_pu_q <= 1'b1;
      gpio_in_q <= 1'b1;
    end else if (clk_en) begin
      gpio_in_q <= opin_sync_q[1];
      if (state_q == ST_RUN && !start_req) begin
        pe7_out_q <= alt_clock_sel ? double_bus_clock_out : gpio_out;
        pe7_oe_q <= alt_clock_sel | gpio_oe;
        pe7_pu_q <= 1'b0;
      end else begin
        pe7_out_q <= 1'b0;
        pe7_oe_q <= 1'b0;
        pe7_pu_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = reset_oe_q;
  assign reset_pin_pullup_en = 1'b1;
  assign port_e_bit_seven_out = pe7_out_q;
  assign port_e_bit_seven_oe = pe7_oe_q;
  assign port_e_bit_seven_pullup_en = pe7_pu_q;
  assign gpio_in = gpio_in_q;
  assign core_reset = core_reset_q;
  assign reset_vector = vector_q;
  assign osc_config_select_n = osc_cfg_q;
  assign full_swing_pierce_sel = ~osc_cfg_q;

endmodule : reset_pin_sequencer

// file: testbench/reset_pin_sequencer_props.sv
`timescale 1ns/1ns
module reset_pin_sequencer_props
  import reset_pin_sequencer_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic watchdog_reset_source,
  input wire logic clock_monitor_reset_source,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_pullup_en,
  input wire logic port_e_bit_seven_oe,
  input wire logic port_e_bit_seven_pullup_en,
  input wire logic core_reset,
  input wire reset_vector_e reset_vector,
  input wire logic osc_config_select_n,
  input wire logic full_swing_pierce_sel
);
  // ------------------------------------------------------------
  // cycle counters, a new request restarts the drive count
  // ------------------------------------------------------------
  logic [8:0] drv_q;
  logic [8:0] gap_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) drv_q <= 9'h000;
    else if (!reset_pin_oe) drv_q <= 9'h000;
    else if (watchdog_reset_source) drv_q <= 9'h000;
    else if (clock_monitor_reset_source) drv_q <= 9'h000;
    else drv_q <= drv_q + 9'h001;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) gap_q <= 9'h000;
    else if (reset_pin_oe || !core_reset) gap_q <= 9'h000;
    else gap_q <= gap_q + 9'h001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_open_drain_pin: assert property (
    !reset_pin_out && reset_pin_pullup_en) else $error("pin not open drain");
  chk_drive_length: assert property (
    $fell(reset_pin_oe) |-> drv_q inside {[9'h07D:9'h082]})
    else $error("reset pin drive length wrong");
  chk_sample_gap: assert property (
    $fell(core_reset) |-> gap_q inside {[9'h03D:9'h044]})
    else $error("sample delay wrong");
  chk_request_drive: assert property (
    !core_reset && (watchdog_reset_source || clock_monitor_reset_source)
    |=> reset_pin_oe && core_reset) else $error("request not driven");
  chk_pin_request: assert property (
    !core_reset && !reset_pin_in |-> ##[1:4] reset_pin_oe)
    else $error("external request missed");
  chk_vector_hold: assert property (
    !core_reset && !$past(core_reset) |-> $stable(reset_vector))
    else $error("vector moved in run");
  chk_osc_hold: assert property (
    !core_reset && !$past(core_reset) |-> $stable(osc_config_select_n))
    else $error("osc config moved in run");
  chk_pierce_select: assert property (
    full_swing_pierce_sel == !osc_config_select_n)
    else $error("pierce select wrong");
  chk_strap_input: assert property (
    core_reset |-> !port_e_bit_seven_oe && port_e_bit_seven_pullup_en)
    else $error("strap pin not input");
endmodule : reset_pin_sequencer_props

bind reset_pin_sequencer reset_pin_sequencer_props i_reset_pin_sequencer_props (
  .clock, .rst, .watchdog_reset_source, .clock_monitor_reset_source,
  .reset_pin_in, .reset_pin_out, .reset_pin_oe, .reset_pin_pullup_en,
  .port_e_bit_seven_oe, .port_e_bit_seven_pullup_en, .core_reset,
  .reset_vector, .osc_config_select_n, .full_swing_pierce_sel);

// file: testbench/reset_board_model.sv
`timescale 1ns/1ns
module reset_board_model (
  input wire logic clock,
  input wire logic reset_pin_oe,
  input wire logic ext_req,
  input wire logic slow,
  input wire logic strap_drive,
  input wire logic strap_val,
  input wire logic port_e_bit_seven_oe,
  input wire logic port_e_bit_seven_out,
  input wire logic port_e_bit_seven_pullup_en,
  output logic reset_pin_in,
  output logic port_e_bit_seven_in
);
  // ------------------------------------------------------------
  // board side of the two pins
  // ------------------------------------------------------------
  logic [7:0] hold_q = 8'h00;
  logic last_q = 1'b0;

  // slow rise stays inside 64 cycles, else internal resets misread
  always_ff @(posedge clock) begin
    if (ext_req) hold_q <= 8'h14;
    else if (reset_pin_oe) hold_q <= slow ? 8'h28 : 8'h00;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
    last_q <= port_e_bit_seven_in;
  end

  // an external request holds the pin low for as long as it stands
  assign reset_pin_in = !(reset_pin_oe || ext_req || hold_q != 8'h00);

  // undriven and unpulled strap pin wobbles instead of holding
  always_comb begin
    if (port_e_bit_seven_oe) port_e_bit_seven_in = port_e_bit_seven_out;
    else if (strap_drive) port_e_bit_seven_in = strap_val;
    else if (port_e_bit_seven_pullup_en) port_e_bit_seven_in = 1'b1;
    else port_e_bit_seven_in = ~last_q;
  end
endmodule : reset_board_model

// file: testbench/reset_pin_sequencer_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, a) \
  begin \
    n_checks++; \
    if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, a); \
    end \
  end

module reset_pin_sequencer_test;
  import reset_pin_sequencer_pkg::*;
  // ------------------------------------------------------------
  // stimulus and checks
  // ------------------------------------------------------------
  logic clock, rst, clk_en, watchdog_reset_source;
  logic clock_monitor_reset_source, self_clock_mode, full_stop;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, reset_pin_pullup_en;
  logic port_e_bit_seven_in, port_e_bit_seven_out, port_e_bit_seven_oe;
  logic port_e_bit_seven_pullup_en, double_bus_clock_out, alt_clock_sel;
  logic gpio_out, gpio_oe, gpio_in, core_reset, osc_config_select_n;
  logic full_swing_pierce_sel, ext_req, slow, strap_drive, strap_val;
  reset_vector_e reset_vector;
  int n_mismatch = 0;
  int n_checks = 0;
  int d, g;

  reset_pin_sequencer i_reset_pin_sequencer (.clock, .rst, .clk_en,
    .watchdog_reset_source, .clock_monitor_reset_source, .self_clock_mode,
    .full_stop, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
    .reset_pin_pullup_en, .port_e_bit_seven_in, .port_e_bit_seven_out,
    .port_e_bit_seven_oe, .port_e_bit_seven_pullup_en, .double_bus_clock_out,
    .alt_clock_sel, .gpio_out, .gpio_oe, .gpio_in, .core_reset,
    .reset_vector, .osc_config_select_n, .full_swing_pierce_sel);

  reset_board_model i_reset_board_model (.clock, .reset_pin_oe, .ext_req,
    .slow, .strap_drive, .strap_val, .port_e_bit_seven_oe,
    .port_e_bit_seven_out, .port_e_bit_seven_pullup_en, .reset_pin_in,
    .port_e_bit_seven_in);

  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick

  // fire a request, then count drive and wait cycles of the sequence
  task automatic go(input logic w, input logic c);
    int n;
    watchdog_reset_source = w;
    clock_monitor_reset_source = c;
    tick();
    watchdog_reset_source = 1'b0;
    clock_monitor_reset_source = 1'b0;
    for (n = 0; n < 8 && core_reset !== 1'b1; n++) tick();
    d = 0;
    g = 0;
    for (n = 0; n < 3000 && core_reset !== 1'b0; n++) begin
      if (reset_pin_oe === 1'b1) d++;
      else g++;
      tick();
    end
  endtask : go

  task automatic expect_seq(input reset_vector_e v, input logic o);
    `CHK("vector", v, reset_vector)
    `CHK("osc cfg", o, osc_config_select_n)
    `CHK("pierce", ~o, full_swing_pierce_sel)
    `CHK("drive", 1'b1, d inside {[126:130]})
    `CHK("gap", 1'b1, g inside {[62:68]})
  endtask : expect_seq

  task automatic t_power_on;
    go(1'b0, 1'b0);
    expect_seq(VEC_EXTERNAL, 1'b0);
  endtask : t_power_on

  task automatic t_internal;
    strap_val = 1'b1;
    go(1'b1, 1'b0);
    expect_seq(VEC_WATCHDOG, 1'b0);
    go(1'b0, 1'b1);
    expect_seq(VEC_CLOCK_MONITOR, 1'b1);
  endtask : t_internal

  task automatic t_low_power;
    for (int i = 0; i < 2; i++) begin
      self_clock_mode = (i == 0);
      full_stop = (i == 1);
      strap_val = i[0];
      go(1'b1, 1'b0);
      expect_seq(VEC_WATCHDOG, i[0]);
    end
    self_clock_mode = 1'b0;
    full_stop = 1'b0;
  endtask : t_low_power

  task automatic t_external;
    strap_val = 1'b0;
    ext_req = 1'b1;
    go(1'b0, 1'b0);
    expect_seq(VEC_EXTERNAL, 1'b1);
    ext_req = 1'b0;
    go(1'b0, 1'b0);
    expect_seq(VEC_EXTERNAL, 1'b1);
  endtask : t_external

  task automatic t_slow_and_restart;
    slow = 1'b1;
    go(1'b1, 1'b0);
    expect_seq(VEC_WATCHDOG, 1'b1);
    slow = 1'b0;
    watchdog_reset_source = 1'b1;
    tick();
    watchdog_reset_source = 1'b0;
    repeat (60) tick();
    go(1'b1, 1'b0);
    expect_seq(VEC_WATCHDOG, 1'b1);
  endtask : t_slow_and_restart

  task automatic t_alt_pin;
    strap_drive = 1'b0;
    alt_clock_sel = 1'b1;
    double_bus_clock_out = 1'b1;
    repeat (4) tick();
    `CHK("alt oe", 1'b1, port_e_bit_seven_oe)
    `CHK("alt out", 1'b1, port_e_bit_seven_out)
    alt_clock_sel = 1'b0;
    gpio_oe = 1'b1;
    repeat (5) tick();
    `CHK("gpio out", 1'b0, port_e_bit_seven_out)
    `CHK("gpio in", 1'b0, gpio_in)
  endtask : t_alt_pin

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run is about 2000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    {watchdog_reset_source, clock_monitor_reset_source} = 2'h0;
    {self_clock_mode, full_stop, double_bus_clock_out} = 3'h0;
    {alt_clock_sel, gpio_out, gpio_oe, ext_req, slow, strap_val} = 6'h00;
    strap_drive = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    t_power_on();
    t_internal();
    t_low_power();
    t_external();
    t_slow_and_restart();
    t_alt_pin();
    end_sim();
  end
endmodule : reset_pin_sequencer_test
